// file: inc/nsw_pkg.sv
package nsw_pkg;
    // register word index on the avalon address
    localparam logic [2:0] REG_DATA_LOW   = 3'h0;
    localparam logic [2:0] REG_DATA_HIGH  = 3'h1;
    localparam logic [2:0] REG_ADDR_LOW   = 3'h2;
    localparam logic [2:0] REG_ADDR_HIGH  = 3'h3;
    localparam logic [2:0] REG_CONTROL    = 3'h4;
    localparam logic [2:0] REG_UNLOCK     = 3'h5;
    // control bit positions
    localparam int CTL_RD     = 0;
    localparam int CTL_WR     = 1;
    localparam int CTL_ALLOW  = 2;
    localparam int CTL_FAULT  = 3;
    localparam int CTL_ERASE  = 4;
    localparam int CTL_LATCH  = 5;
    localparam int CTL_REGION = 6;
    // unlock key bytes
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    // word layout
    localparam int WORD_W = 14;
    localparam int ADDR_W = 15;
    localparam int ROW_W  = 5;
    localparam logic [13:0] BLANK_WORD = 14'h3fff;
    localparam logic [1:0]  HIGH_PAD   = 2'h0;
    localparam logic        ADDR_PAD   = 1'h1;
    // region-1 address windows, region bit excluded
    localparam logic [14:0] UID_LO  = 15'h0000;
    localparam logic [14:0] UID_HI  = 15'h0003;
    localparam logic [14:0] ID_LO   = 15'h0005;
    localparam logic [14:0] CFG_HI  = 15'h000a;
    localparam logic [14:0] EE_LO   = 15'h7000;
    localparam logic [14:0] EE_HI   = 15'h70ff;
    // self-timed durations
    localparam int CLK_PERIOD_NS = 10;
    localparam int ERASE_TIME_NS = 2000000;
    localparam int WRITE_TIME_NS = 2000000;
    localparam int EE_TIME_NS    = 4000000;
    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_EE} nsw_state_t;
    typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} nsw_key_t;
endpackage : nsw_pkg

// file: verilog/nsw_ctrl.sv
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - write trigger on protected address sets fault, except a latch-only load
// - reset during self-write sets fault
// - interrupted unlock key sets fault
// - fault settable by software, cleared by software or by a reset while idle
// - row write flushes latches, latches go blank
// - latch-only copies data pair into latch
// - erase sets whole 32-word row to ones
// - protected row write/erase: no operation, fault
// - erase ignores latch-only bit
// - region bit picks eeprom/config or flash
// - read trigger loads data, then self-clears
// - eeprom read updates low data byte only
// - eeprom write uses low data byte only
// - program-allow gates all program and erase
// - write trigger only right after unlock key
// - operations self-timed, trigger cleared at end
// - clearing trigger mid-operation has no effect
// - eeprom address: trigger starts single-word cycle
// - erase bit cleared after normal erase
// - top two data-high bits read zero
// - fault meaningful only after trigger clears
// - interrupted key starts no load or write
// - unreadable region address reads zero
module nsw_ctrl
#(
    parameter int P_ERASE_CYCLES = nsw_pkg::ERASE_TIME_NS / nsw_pkg::CLK_PERIOD_NS,
    parameter int P_WRITE_CYCLES = nsw_pkg::WRITE_TIME_NS / nsw_pkg::CLK_PERIOD_NS,
    parameter int P_EE_CYCLES    = nsw_pkg::EE_TIME_NS / nsw_pkg::CLK_PERIOD_NS
)
(
    // clock and reset
    input  wire logic                        i_clock,
    input  wire logic                        i_reset,
    // avalon-mm slave
    input  wire logic [2:0]                  i_avs_address,
    input  wire logic                        i_avs_read,
    input  wire logic                        i_avs_write,
    input  wire logic [3:0]                  i_avs_byteenable,
    input  wire logic [31:0]                 i_avs_writedata,
    output logic [31:0]                      o_avs_readdata,
    output logic                             o_avs_waitrequest,
    // flash array side
    input  wire logic [nsw_pkg::WORD_W-1:0]  i_mem_rdata,
    input  wire logic                        i_flash_protected,
    output logic                             o_mem_read,
    output logic                             o_mem_erase,
    output logic                             o_mem_program,
    output logic                             o_mem_ee_write,
    output logic                             o_mem_region,
    output logic [nsw_pkg::ADDR_W-1:0]       o_mem_addr,
    output logic [nsw_pkg::WORD_W-1:0]       o_mem_wdata,
    output logic [32*nsw_pkg::WORD_W-1:0]    o_mem_row_data
);
    import nsw_pkg::*;

    localparam int ROWS = 1 << ROW_W;

    // the countdown is 30 bits wide, so no duration may exceed its range
    if (P_ERASE_CYCLES < 1 || P_WRITE_CYCLES < 1 || P_EE_CYCLES < 1 ||
        P_ERASE_CYCLES > (1 << 30) || P_WRITE_CYCLES > (1 << 30) || P_EE_CYCLES > (1 << 30))
    begin : g_bad_durations
        $error("nsw_ctrl: duration parameters out of range");
    end

    nsw_state_t          state_r;
    nsw_key_t            key_r;
    logic                ack_r;
    logic [31:0]         readdata_r;
    logic [7:0]          data_lo_r;
    logic [5:0]          data_hi_r;
    logic [ADDR_W-1:0]   addr_r;
    logic                region_r;
    logic                latch_only_r;
    logic                erase_r;
    logic                allow_r;
    logic                fault_r;
    logic                rd_r;
    logic [29:0]         cnt_r;
    logic [WORD_W-1:0]   latch_r [ROWS];

    logic                bus_wr;
    logic [7:0]          wbyte;
    logic                ctl_wr;
    logic                wr_cmd;
    logic                key_break;
    logic                go;
    logic                in_uid;
    logic                in_id;
    logic                in_ee;
    logic                prot_hit;
    logic                go_fault;
    logic                go_latch;
    logic                finish;
    logic                busy;
    logic [7:0]          rd_mux;

    // avalon: one wait cycle, then the access completes
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
    assign o_avs_readdata    = readdata_r;
    assign bus_wr = i_avs_write & ack_r & i_avs_byteenable[0];
    assign wbyte  = i_avs_writedata[7:0];
    assign ctl_wr = bus_wr & (i_avs_address == REG_CONTROL);
    assign wr_cmd = ctl_wr & wbyte[CTL_WR];
    assign busy   = (state_r != ST_IDLE);

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            ack_r <= 1'b0;
        else
            ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
    end

    always_comb
    begin
        unique case (i_avs_address)
            REG_DATA_LOW:  rd_mux = data_lo_r;
            REG_DATA_HIGH: rd_mux = {HIGH_PAD, data_hi_r};
            REG_ADDR_LOW:  rd_mux = addr_r[7:0];
            REG_ADDR_HIGH: rd_mux = {ADDR_PAD, addr_r[14:8]};
            REG_CONTROL:   rd_mux = {1'b0, region_r, latch_only_r, erase_r, fault_r, allow_r, busy, rd_r};
            default:       rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            readdata_r <= 32'h0000_0000;
        else if (i_avs_read & ~ack_r)
            readdata_r <= {24'h00_0000, rd_mux};
    end

    // region-1 windows
    assign in_uid = (addr_r >= UID_LO) && (addr_r <= UID_HI);
    assign in_id  = (addr_r >= ID_LO) && (addr_r <= CFG_HI);
    assign in_ee  = (addr_r >= EE_LO) && (addr_r <= EE_HI);
    // only user ids and eeprom are writable in region 1
    assign prot_hit = wbyte[CTL_REGION] ? ~(in_uid | in_ee) : i_flash_protected;

    // unlock key tracking; any other write in between breaks the sequence
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            key_r <= KEY_IDLE;
        else if (bus_wr)
        begin
            if (i_avs_address == REG_UNLOCK)
            begin
                unique case (key_r)
                    KEY_IDLE:  key_r <= (wbyte == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
                    KEY_HALF:  key_r <= (wbyte == KEY_SECOND) ? KEY_ARMED : KEY_IDLE;
                    KEY_ARMED: key_r <= KEY_IDLE;
                endcase
            end
            else
                key_r <= KEY_IDLE;
        end
    end

    assign key_break = bus_wr & (((key_r == KEY_HALF) & ~((i_avs_address == REG_UNLOCK) & (wbyte == KEY_SECOND)))
                               | ((key_r == KEY_ARMED) & ~wr_cmd));

    // trigger accepted only straight after the key, while idle and allowed
    assign go       = wr_cmd & (key_r == KEY_ARMED) & ~busy & wbyte[CTL_ALLOW];
    assign go_latch = go & ~wbyte[CTL_REGION] & ~wbyte[CTL_ERASE] & wbyte[CTL_LATCH];
    assign go_fault = go & ~go_latch & prot_hit;
    assign finish   = busy & (cnt_r == 30'h0000_0000);

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            state_r <= ST_IDLE;
            cnt_r   <= 30'h0000_0000;
        end
        else if (finish)
            state_r <= ST_IDLE;
        else if (busy)
            cnt_r <= cnt_r - 30'h0000_0001;
        else if (go & ~go_latch & ~go_fault)
        begin
            if (wbyte[CTL_REGION])
            begin
                state_r <= ST_EE;
                cnt_r   <= 30'(P_EE_CYCLES - 1);
            end
            else if (wbyte[CTL_ERASE])
            begin
                state_r <= ST_ERASE;
                cnt_r   <= 30'(P_ERASE_CYCLES - 1);
            end
            else
            begin
                state_r <= ST_PROG;
                cnt_r   <= 30'(P_WRITE_CYCLES - 1);
            end
        end
    end

    // fault flag: hardware set beats a software clear
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            fault_r <= busy;
        else if (go_fault | key_break)
            fault_r <= 1'b1;
        else if (ctl_wr)
            fault_r <= wbyte[CTL_FAULT];
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            region_r     <= 1'b0;
            latch_only_r <= 1'b0;
            allow_r      <= 1'b0;
        end
        else if (ctl_wr)
        begin
            region_r     <= wbyte[CTL_REGION];
            latch_only_r <= wbyte[CTL_LATCH];
            allow_r      <= wbyte[CTL_ALLOW];
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            erase_r <= 1'b0;
        else if (finish & (state_r == ST_ERASE))
            erase_r <= 1'b0;
        else if (ctl_wr & ~busy)
            erase_r <= wbyte[CTL_ERASE];
    end

    // read trigger can only be set; it drops after its single fetch cycle
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            rd_r <= 1'b0;
        else if (rd_r)
            rd_r <= 1'b0;
        else if (ctl_wr & wbyte[CTL_RD] & ~busy)
            rd_r <= 1'b1;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            addr_r <= 15'h0000;
        else if (bus_wr & (i_avs_address == REG_ADDR_LOW) & ~busy)
            addr_r[7:0] <= wbyte;
        else if (bus_wr & (i_avs_address == REG_ADDR_HIGH) & ~busy)
            addr_r[14:8] <= wbyte[6:0];
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            data_lo_r <= 8'h00;
            data_hi_r <= 6'h00;
        end
        else if (rd_r)
        begin
            if (region_r & ~(in_uid | in_id | in_ee))
            begin
                data_lo_r <= 8'h00;
                data_hi_r <= 6'h00;
            end
            else if (region_r & in_ee)
                data_lo_r <= i_mem_rdata[7:0];
            else
            begin
                data_lo_r <= i_mem_rdata[7:0];
                data_hi_r <= i_mem_rdata[13:8];
            end
        end
        else if (bus_wr & (i_avs_address == REG_DATA_LOW) & ~busy)
            data_lo_r <= wbyte;
        else if (bus_wr & (i_avs_address == REG_DATA_HIGH) & ~busy)
            data_hi_r <= wbyte[5:0];
    end

    // write latches, back to blank after every row write or erase
    always_ff @(posedge i_clock)
    begin
        if (i_reset | (finish & ((state_r == ST_PROG) | (state_r == ST_ERASE))))
        begin
            for (int i = 0; i < ROWS; i++)
                latch_r[i] <= BLANK_WORD;
        end
        else if (go_latch)
            latch_r[addr_r[ROW_W-1:0]] <= {data_hi_r, data_lo_r};
    end

    always_comb
    begin
        for (int i = 0; i < ROWS; i++)
            o_mem_row_data[i*WORD_W +: WORD_W] = latch_r[i];
    end

    // erase, program and eeprom-write strobes stay high for the whole self-timed interval; the read strobe lasts one cycle
    assign o_mem_read     = rd_r;
    assign o_mem_erase    = (state_r == ST_ERASE);
    assign o_mem_program  = (state_r == ST_PROG);
    assign o_mem_ee_write = (state_r == ST_EE);
    assign o_mem_region   = region_r;
    assign o_mem_addr     = addr_r;
    // eeprom cells are a byte wide, so the high byte is dropped
    assign o_mem_wdata    = (region_r & in_ee) ? {6'h00, data_lo_r} : {data_hi_r, data_lo_r};

    property p_prot_fault;
        @(posedge i_clock) disable iff (i_reset)
        go_fault |=> fault_r && !busy;
    endproperty
    a_prot_fault: assert property (p_prot_fault) else $error("protected trigger gave no fault");

    property p_key_fault;
        @(posedge i_clock) disable iff (i_reset)
        key_break |=> fault_r && !$rose(busy) && ($past(finish) || $stable(o_mem_row_data));
    endproperty
    a_key_fault: assert property (p_key_fault) else $error("broken key did not fault");

    property p_fault_sticky;
        @(posedge i_clock) disable iff (i_reset)
        $fell(fault_r) |-> $past(ctl_wr) && !$past(wbyte[CTL_FAULT]);
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault cleared by hardware");

    property p_latch_load;
        @(posedge i_clock) disable iff (i_reset)
        go_latch |=> latch_r[addr_r[ROW_W-1:0]] == {data_hi_r, data_lo_r} && !busy;
    endproperty
    a_latch_load: assert property (p_latch_load) else $error("latch not loaded");

    property p_read_once;
        @(posedge i_clock) disable iff (i_reset)
        $rose(rd_r) |=> !rd_r;
    endproperty
    a_read_once: assert property (p_read_once) else $error("read trigger did not self-clear");

    property p_start_needs_key;
        @(posedge i_clock) disable iff (i_reset)
        $rose(busy) |-> $past(key_r) == KEY_ARMED && $past(wbyte[CTL_ALLOW]);
    endproperty
    a_start_needs_key: assert property (p_start_needs_key) else $error("operation without key");

    property p_erase_clears;
        @(posedge i_clock) disable iff (i_reset)
        finish && state_r == ST_ERASE |=> !erase_r && !busy && latch_r[0] == BLANK_WORD;
    endproperty
    a_erase_clears: assert property (p_erase_clears) else $error("erase bit not cleared");

    property p_allow_gate;
        @(posedge i_clock) disable iff (i_reset)
        wr_cmd && !busy && !wbyte[CTL_ALLOW] |=> !busy;
    endproperty
    a_allow_gate: assert property (p_allow_gate) else $error("operation while not allowed");

    property p_held;
        @(posedge i_clock) disable iff (i_reset)
        $rose(busy) && cnt_r > 30'h0000_0001 |-> busy [*2];
    endproperty
    a_held: assert property (p_held) else $error("trigger dropped early");

endmodule : nsw_ctrl
`default_nettype wire

// file: verification/nsw_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module nsw_ctrl_tb;
    import nsw_pkg::*;
    // short self-timed counts keep the run brief
    localparam int PE = 10;
    localparam int PW = 12;
    localparam int PX = 14;
    logic                 i_clock           = 1'b0;
    logic                 i_reset           = 1'b1;
    logic [2:0]           i_avs_address     = 3'h0;
    logic                 i_avs_read        = 1'b0;
    logic                 i_avs_write       = 1'b0;
    logic [3:0]           i_avs_byteenable  = 4'h1;
    logic [31:0]          i_avs_writedata   = 32'h0;
    logic [31:0]          o_avs_readdata;
    logic                 o_avs_waitrequest;
    logic [WORD_W-1:0]    i_mem_rdata       = 14'h0;
    logic                 i_flash_protected = 1'b0;
    logic                 o_mem_read;
    logic                 o_mem_erase;
    logic                 o_mem_program;
    logic                 o_mem_ee_write;
    logic                 o_mem_region;
    logic [ADDR_W-1:0]    o_mem_addr;
    logic [WORD_W-1:0]    o_mem_wdata;
    logic [32*WORD_W-1:0] o_mem_row_data;
    logic [31:0]          seed              = 32'h36;
    logic [31:0]          expq[$];
    logic [2:0]           op_seen           = 3'h0;
    logic [13:0]          op_wd             = 14'h0;
    int                   op_cyc            = 0;
    int                   errors            = 0;
    int                   n_tests           = 0;
    int                   cycles            = 0;
    int                   n_rd              = 0;
    logic [31:0]          r;
    int                   k;

    nsw_ctrl #(.P_ERASE_CYCLES(PE), .P_WRITE_CYCLES(PW), .P_EE_CYCLES(PX)) u_nsw_ctrl (
        .i_clock(i_clock), .i_reset(i_reset), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_byteenable(i_avs_byteenable), .i_avs_writedata(i_avs_writedata),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_mem_rdata(i_mem_rdata),
        .i_flash_protected(i_flash_protected), .o_mem_read(o_mem_read), .o_mem_erase(o_mem_erase),
        .o_mem_program(o_mem_program), .o_mem_ee_write(o_mem_ee_write), .o_mem_region(o_mem_region),
        .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_mem_row_data(o_mem_row_data));

    always #5 i_clock = ~i_clock;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic close_out();
        if (errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic tally(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : tally

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        tally(got, exp);
    endtask : chk_rd

    task automatic chk_op(input logic [31:0] got, input logic [31:0] exp);
        tally(got, exp);
    endtask : chk_op

    // readdata is taken only at the edge that ends the wait
    always @(posedge i_clock)
        if (i_avs_read && o_avs_waitrequest === 1'b0 && expq.size() > 0)
            chk_rd(o_avs_readdata, expq.pop_front());

    // a hung handshake must still reach the verdict
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            close_out();
        end
    end

    always @(posedge i_clock)
        if ({o_mem_erase, o_mem_program, o_mem_ee_write} != 3'h0)
        begin
            op_seen <= op_seen | {o_mem_erase, o_mem_program, o_mem_ee_write};
            op_cyc  <= op_cyc + 1;
            op_wd   <= o_mem_wdata;
        end

    // counts single-cycle array read strobes
    always @(posedge i_clock)
        n_rd <= n_rd + int'(o_mem_read);

    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        i_avs_address   <= a;
        i_avs_writedata <= {24'h0, d};
        i_avs_write     <= w;
        i_avs_read      <= ~w;
        do @(posedge i_clock); while (o_avs_waitrequest !== 1'b0);
        i_avs_write <= 1'b0;
        i_avs_read  <= 1'b0;
        // one idle edge so the next call never re-raises a strobe in this step
        @(posedge i_clock);
    endtask : bus

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        expq.push_back({24'h0, e});
        bus(1'b0, a, 8'h0);
    endtask : rd

    task automatic key(input logic [7:0] c);
        wr(REG_UNLOCK, KEY_FIRST);
        wr(REG_UNLOCK, KEY_SECOND);
        wr(REG_CONTROL, c);
    endtask : key

    task automatic op_chk(input logic [2:0] m, input int n);
        repeat (PX + 4) @(posedge i_clock);
        chk_op({29'h0, op_seen}, {29'h0, m});
        chk_op(op_cyc, n);
        op_seen = 3'h0;
        op_cyc  = 0;
    endtask : op_chk

    initial
    begin
        repeat (10) @(posedge i_clock);
        i_reset <= 1'b0;
        rd(REG_DATA_LOW, 8'h00);
        rd(REG_ADDR_HIGH, 8'h80);
        rd(REG_CONTROL, 8'h00);
        rd(REG_UNLOCK, 8'h00);
        wr(3'h6, 8'h5a);
        rd(3'h6, 8'h00);
        wr(REG_DATA_HIGH, 8'hff);
        rd(REG_DATA_HIGH, 8'h3f);
        r = xs();
        i_mem_rdata <= r[13:0];
        wr(REG_ADDR_LOW, 8'h04);
        wr(REG_CONTROL, 8'h01);
        repeat (2) @(posedge i_clock);
        rd(REG_DATA_LOW, r[7:0]);
        rd(REG_DATA_HIGH, {2'h0, r[13:8]});
        rd(REG_CONTROL, 8'h00);
        wr(REG_CONTROL, 8'h41);
        repeat (2) @(posedge i_clock);
        rd(REG_DATA_LOW, 8'h00);
        wr(REG_DATA_HIGH, 8'h15);
        wr(REG_ADDR_HIGH, 8'h70);
        wr(REG_CONTROL, 8'h41);
        repeat (2) @(posedge i_clock);
        rd(REG_DATA_LOW, r[7:0]);
        rd(REG_DATA_HIGH, 8'h15);
        wr(REG_ADDR_HIGH, 8'h00);
        // first and last latch of the row
        for (k = 0; k < 32; k += 31)
        begin
            r = xs();
            wr(REG_ADDR_LOW, k[7:0]);
            wr(REG_DATA_LOW, r[7:0]);
            wr(REG_DATA_HIGH, {2'h0, r[13:8]});
            key(8'h26);
            repeat (2) @(posedge i_clock);
            chk_op({18'h0, o_mem_row_data[k*14 +: 14]}, {18'h0, r[13:0]});
        end
        op_chk(3'h0, 0);
        key(8'h06);
        @(posedge i_clock);
        rd(REG_CONTROL, 8'h06);
        wr(REG_CONTROL, 8'h04);
        rd(REG_CONTROL, 8'h06);
        op_chk(3'b010, PW);
        chk_op({31'h0, o_mem_row_data === {32{BLANK_WORD}}}, 32'h1);
        rd(REG_CONTROL, 8'h04);
        key(8'h36);
        op_chk(3'b100, PE);
        rd(REG_CONTROL, 8'h24);
        r = xs();
        wr(REG_ADDR_HIGH, 8'h70);
        wr(REG_ADDR_LOW, 8'h05);
        wr(REG_DATA_LOW, r[7:0]);
        wr(REG_DATA_HIGH, 8'h3f);
        key(8'h46);
        op_chk(3'b001, PX);
        chk_op({18'h0, op_wd}, {24'h0, r[7:0]});
        chk_op({16'h0, o_mem_region, o_mem_addr}, 32'h0000_f005);
        i_flash_protected <= 1'b1;
        wr(REG_ADDR_HIGH, 8'h00);
        key(8'h06);
        op_chk(3'h0, 0);
        rd(REG_CONTROL, 8'h0c);
        wr(REG_CONTROL, 8'h04);
        rd(REG_CONTROL, 8'h04);
        wr(REG_CONTROL, 8'h0c);
        rd(REG_CONTROL, 8'h0c);
        wr(REG_CONTROL, 8'h04);
        i_flash_protected <= 1'b0;
        wr(REG_UNLOCK, KEY_FIRST);
        wr(REG_UNLOCK, KEY_SECOND);
        wr(REG_DATA_LOW, 8'h11);
        rd(REG_CONTROL, 8'h0c);
        wr(REG_CONTROL, 8'h0e);
        op_chk(3'h0, 0);
        key(8'h02);
        op_chk(3'h0, 0);
        rd(REG_CONTROL, 8'h00);
        // one reset edge while a row write runs
        key(8'h06);
        repeat (3) @(posedge i_clock);
        i_reset <= 1'b1;
        @(posedge i_clock);
        i_reset <= 1'b0;
        rd(REG_CONTROL, 8'h08);
        repeat (3) @(posedge i_clock);
        chk_op(n_rd, 32'h3);
        close_out();
    end
endmodule : nsw_ctrl_tb
`default_nettype wire
